// file: verilog/spi_slave_command_checker.v
// Serial slave port with mode state machine and command validation.
// Assumes a master on asynchronous pins and wake events on clk_in.
// Function
// [R1] Port live only in Init, Normal, Stop.
// [R2] Full-duplex 32-bit frames, own chip select.
// [R3] Chip-select rise interprets word, releases output.
// [R4] Sample input on every serial clock fall.
// [R5] Shift output after rises; no input forwarding.
// [R6] Illegal command sets failure, discards whole write; code still writes the mode bits of a Sleep request failed for no wake source.
// [R7] Failure flag cleared only by serial clear.
// [R8] Stop to Sleep fails, enters Restart.
// [R9] Init to Stop/Sleep fails, enters Normal.
// [R10] Odd watchdog parity fails, write ignored.
// [R11] Stop allows trigger, Normal, reset, status.
// [R12] Stop without wake sources raises no failure.
// [R13] Stop with pending wakes pulses interrupt.
// [R14] Stop to Normal ignores other bits.
// [R15] Sleep without wake source fails, Restart.
// [R16] Timer-only wake, timer off: Restart.
// [R17] On-time not below period fails; code accepts any on-time when period is zero.
// [R18] All-zero or all-one frame fails, discarded.
// [R19] Pin configuration writable only once.
// [R20] Sync high-side needs sync pin configured.
// [R21] Unused addresses ignored without failure.
// [R22] Checksum mode: Init fails stay; first frame Normal.
// [R23] Address 6:0, selector 7, data 23:8.
// [R24] Restart mode ignores serial traffic.
// [R25] Accepted changes apply at chip-select rise.
`include "spi_checker_consts.vh"
module spi_slave_command_checker #(
  parameter RESTART_CYCLES = (`RESTART_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter INT_CYCLES     = (`INT_LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire        clk_in,                     // System clock, 100 MHz.
  input  wire        rst_in,                     // Asynchronous reset, active high.
  input  wire        csn_in,                     // Chip select pin, active low.
  input  wire        sclk_in,                    // Serial clock pin.
  input  wire        sdi_in,                     // Serial data input pin.
  input  wire        pwm_or_checksum_select_in,  // Checksum framing selected.
  input  wire        crc_error_in,               // Checksum of this frame bad.
  input  wire [7:0]  wake_event_in,              // Wake event pulses.
  input  wire        fail_safe_req_in,           // Fail-safe request level.
  output wire        sdo_out,                    // Serial data output.
  output wire        sdo_oe_out,                 // Serial output enable.
  output reg  [5:0]  mode_out,                   // One-hot device mode.
  output reg         spi_fail_out,               // Command-failure flag.
  output reg         crc_fail_out,               // Checksum-failure flag.
  output reg  [7:0]  wake_status_out,            // Sticky wake status.
  output reg         wd_trigger_out,             // Watchdog trigger pulse.
  output reg  [15:0] watchdog_control_out,       // Watchdog settings.
  output reg  [15:0] bus_wake_ctrl_out,          // Bus wake enables.
  output reg  [15:0] wake_source_control_out,    // Wake source enables.
  output reg  [15:0] timer_ctrl_out,             // Timer period and on-time.
  output reg  [3:0]  high_side_sync_out,         // High-side sync assignment.
  output reg  [15:0] pin_cfg_out,                // Wake/fail and sync pin config.
  output reg  [13:0] mode_cfg_out,               // Other mode control bits.
  output reg         interrupt_output_n_out      // Interrupt output, active low.
);

  // ====================================================================
  // Mode encodings.
  localparam [5:0] M_INIT     = 6'h01;
  localparam [5:0] M_NORMAL   = 6'h02;
  localparam [5:0] M_STOP     = 6'h04;
  localparam [5:0] M_SLEEP    = 6'h08;
  localparam [5:0] M_RESTART  = 6'h10;
  localparam [5:0] M_FAILSAFE = 6'h20;

  // ====================================================================
  // Pin sampling and framing.
  wire [2:0]  lvl;          // Synchronised csn, sclk, sdi.
  wire [2:0]  rise;         // Rising edge pulses.
  wire [2:0]  fall;         // Falling edge pulses.
  wire [31:0] rx;           // Received word.
  wire [5:0]  count;        // Bits received.
  wire        tx_bit;       // Current output bit.
  reg         in_frame;     // A frame began while the port was live.
  reg         pin_locked;   // Pin configuration already written.
  reg  [15:0] rd_data;      // Readback of the last addressed register.
  reg  [31:0] int_count;    // Interrupt low time counter.
  reg  [31:0] rst_count;    // Restart dwell counter.
  wire        port_on = |(mode_out & (M_INIT | M_NORMAL | M_STOP)); // R1 R24
  wire        start   = fall[0] & port_on;
  wire        commit  = rise[0] & in_frame & port_on; // R3 R25

  pin_sampler #(.WIDTH(3), .IDLE(3'h1)) u_pins (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pins_in   ({sdi_in, sclk_in, csn_in}),
    .level_out (lvl),
    .rise_out  (rise),
    .fall_out  (fall)
  );

  frame_shifter #(.BITS(`FRAME_BITS)) u_shift (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .start_in  (start),
    .active_in (in_frame & ~lvl[0]),
    .rise_in   (rise[1]),
    .fall_in   (fall[1]),
    .sdi_in    (lvl[2]),
    .load_in   ({8'h00, rd_data, spi_fail_out | crc_fail_out, 3'h0, |wake_status_out, 3'h0}),
    .rx_out    (rx),
    .count_out (count),
    .sdo_out   (tx_bit)
  );

  // Output drives only inside a live frame; released at chip-select rise.
  assign sdo_out    = tx_bit; // R5
  assign sdo_oe_out = in_frame & ~lvl[0] & port_on; // R3 R1

  // ====================================================================
  // Frame fields.
  wire [6:0]  addr  = rx[`ADDR_MSB:`ADDR_LSB]; // R23
  wire        wr    = rx[`RW_BIT];             // R23
  wire [15:0] data  = rx[`DATA_MSB:`DATA_LSB]; // R23
  wire [1:0]  req   = data[`MODE_FLD_MSB:`MODE_FLD_LSB];
  wire        stuck = (rx == 32'h00000000) | (rx == 32'hFFFFFFFF);
  wire        no_wk = (bus_wake_ctrl_out == `RST_CFG16) & (wake_source_control_out == `RST_CFG16);
  wire        t_only = (bus_wake_ctrl_out == `RST_CFG16) &
                       (wake_source_control_out == (16'h0001 << `WAKE_TIMER_BIT));
  wire        t_off = (timer_ctrl_out[`TIMER_PER_MSB:`TIMER_PER_LSB] == 8'h00);

  // ====================================================================
  // Command evaluation.
  // Decides the new mode, flags and settings for a complete frame.
  reg        set_fail;    // Command failure raised.
  reg        wd_pulse;    // Watchdog trigger accepted.
  reg        stop_int;    // Stop entered with wakes pending.
  reg        clr_dev;     // Device status read-and-clear.
  reg        clr_wk;      // Wake status read-and-clear.
  reg        soft_rst;    // Soft reset requested.
  reg  [5:0] next_mode;
  reg [13:0] next_mode_cfg;
  reg [15:0] next_wd;
  reg [15:0] next_bus;
  reg [15:0] next_wk;
  reg [15:0] next_timer;
  reg  [3:0] next_hs;
  reg [15:0] next_pin;
  reg        next_lock;
  reg [15:0] next_rd;
  always @* begin
    set_fail      = 1'b0;
    wd_pulse      = 1'b0;
    stop_int      = 1'b0;
    clr_dev       = 1'b0;
    clr_wk        = 1'b0;
    soft_rst      = 1'b0;
    next_mode     = mode_out;
    next_mode_cfg = mode_cfg_out;
    next_wd       = watchdog_control_out;
    next_bus      = bus_wake_ctrl_out;
    next_wk       = wake_source_control_out;
    next_timer    = timer_ctrl_out;
    next_hs       = high_side_sync_out;
    next_pin      = pin_cfg_out;
    next_lock     = pin_locked;
    // Readback of the addressed register; unused addresses read zero.
    case (addr)
      `ADDR_MODE_CTRL:  next_rd = {mode_cfg_out, 2'h0};
      `ADDR_WATCHDOG_CONTROL_REGISTER:    next_rd = watchdog_control_out;
      `ADDR_BUS_CTRL:   next_rd = bus_wake_ctrl_out;
      `ADDR_WAKE_CTRL:  next_rd = wake_source_control_out;
      `ADDR_TIMER_CTRL: next_rd = timer_ctrl_out;
      `ADDR_HS_CTRL:    next_rd = {12'h000, high_side_sync_out};
      `ADDR_PIN_CFG:    next_rd = pin_cfg_out;
      `ADDR_WAKE_STAT:  next_rd = {8'h00, wake_status_out};
      `ADDR_DEV_STAT:   next_rd = {14'h0000, crc_fail_out, spi_fail_out};
      default:          next_rd = 16'h0000;
    endcase
    if (stuck) begin
      set_fail = 1'b1; // R18
    end else if (wr) begin
      case (addr)
        `ADDR_MODE_CTRL: begin
          case (req)
            `MODE_REQ_NORMAL: begin
              next_mode = M_NORMAL;
              if (mode_out != M_STOP) begin
                next_mode_cfg = data[15:2];
              end // R14: stop to normal keeps other bits
            end
            `MODE_REQ_SLEEP: begin
              if (mode_out == M_INIT) begin
                set_fail  = 1'b1; // R9 R22
                next_mode = M_NORMAL;
              end else if (mode_out == M_STOP) begin
                set_fail  = 1'b1; // R8 R11
                next_mode = M_RESTART;
              end else if (no_wk) begin
                set_fail      = 1'b1; // R15
                next_mode     = M_RESTART;
                next_mode_cfg = data[15:2];
              end else begin
                next_mode_cfg = data[15:2];
                next_mode     = (t_only & t_off) ? M_RESTART : M_SLEEP; // R16
              end
            end
            `MODE_REQ_STOP: begin
              if (mode_out == M_INIT) begin
                set_fail  = 1'b1; // R9 R22
                next_mode = M_NORMAL;
              end else if (mode_out == M_NORMAL) begin
                next_mode     = M_STOP; // R12
                next_mode_cfg = data[15:2];
                stop_int      = |wake_status_out; // R13
              end
            end
            default: begin
              soft_rst  = 1'b1; // R11
              next_mode = M_RESTART;
            end
          endcase
        end
        `ADDR_WATCHDOG_CONTROL_REGISTER: begin
          if (^data) begin
            set_fail = 1'b1; // R10
          end else begin
            wd_pulse = 1'b1;
            if (mode_out != M_STOP) begin
              next_wd = data;
            end
          end
        end
        `ADDR_WAKE_STAT: clr_wk = 1'b1;
        `ADDR_DEV_STAT:  clr_dev = 1'b1; // R7
        `ADDR_BUS_CTRL, `ADDR_WAKE_CTRL, `ADDR_TIMER_CTRL, `ADDR_HS_CTRL, `ADDR_PIN_CFG: begin
          if (mode_out == M_STOP) begin
            set_fail = 1'b1; // R11
          end else if (addr == `ADDR_BUS_CTRL) begin
            next_bus = data;
          end else if (addr == `ADDR_WAKE_CTRL) begin
            next_wk = data;
          end else if (addr == `ADDR_TIMER_CTRL) begin
            if (data[`TIMER_ON_MSB:`TIMER_ON_LSB] >= data[`TIMER_PER_MSB:`TIMER_PER_LSB] &&
                data[`TIMER_PER_MSB:`TIMER_PER_LSB] != 8'h00) begin
              set_fail = 1'b1; // R17
            end else begin
              next_timer = data;
            end
          end else if (addr == `ADDR_HS_CTRL) begin
            if ((|data[3:0]) & ~pin_cfg_out[`PIN_SYNC_BIT]) begin
              set_fail = 1'b1; // R20
            end else begin
              next_hs = data[3:0];
            end
          end else if (pin_locked) begin
            set_fail = 1'b1; // R19
          end else begin
            next_pin  = data;
            next_lock = 1'b1;
          end
        end
        default: ;  // R21
      endcase
    end
    // The first complete frame leaves Init for Normal, or for Restart on a reset request.
    if (mode_out == M_INIT && next_mode == M_INIT) begin
      next_mode = M_NORMAL; // R22
    end
  end

  // ====================================================================
  // Frame tracking.
  // A frame counts only if it began while the port was live.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_frame <= 1'b0;
    end else if (start) begin
      in_frame <= 1'b1; // R2
    end else if (rise[0] | ~port_on) begin
      in_frame <= 1'b0; // R1 R24
    end
  end

  // ====================================================================
  // State, settings and flags.
  // Settings change only at the chip-select rise of a 32-bit frame, or to reset values in Restart.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_out                <= M_INIT;
      spi_fail_out            <= 1'b0;
      crc_fail_out            <= 1'b0;
      wake_status_out         <= `RST_WSTAT;
      wd_trigger_out          <= 1'b0;
      watchdog_control_out    <= `RST_CFG16;
      bus_wake_ctrl_out       <= `RST_CFG16;
      wake_source_control_out <= `RST_CFG16;
      timer_ctrl_out          <= `RST_CFG16;
      high_side_sync_out      <= `RST_HS4;
      pin_cfg_out             <= `RST_CFG16;
      mode_cfg_out            <= 14'h0000;
      pin_locked              <= 1'b0;
      rd_data                 <= `RST_CFG16;
      rst_count               <= 32'h00000000;
      int_count               <= 32'h00000000;
      interrupt_output_n_out  <= 1'b0;
    end else begin
      wd_trigger_out <= 1'b0;
      wake_status_out <= (wake_status_out & ~((commit && count == 6'd32 && clr_wk) ? 8'hFF : 8'h00))
                         | wake_event_in;
      int_count <= (int_count != 32'h00000000) ? int_count - 32'h00000001 : 32'h00000000;
      if (commit && count == 6'd32) begin
        rd_data        <= next_rd;
        mode_out       <= next_mode; // R25
        wd_trigger_out <= wd_pulse & ~set_fail;
        spi_fail_out   <= (spi_fail_out & ~clr_dev) | set_fail; // R6 R7
        crc_fail_out   <= (crc_fail_out & ~clr_dev) | (crc_error_in & pwm_or_checksum_select_in); // R22
        if (stop_int) begin
          int_count <= INT_CYCLES; // R13
        end
        if (soft_rst | next_mode == M_RESTART) begin
          mode_cfg_out <= next_mode_cfg; // R15
        end else if (!set_fail) begin // R6
          mode_cfg_out            <= next_mode_cfg;
          watchdog_control_out    <= next_wd;
          bus_wake_ctrl_out       <= next_bus;
          wake_source_control_out <= next_wk;
          timer_ctrl_out          <= next_timer;
          high_side_sync_out      <= next_hs;
          pin_cfg_out             <= next_pin;
          pin_locked              <= next_lock;
        end
        rst_count <= RESTART_CYCLES;
      end else if (fail_safe_req_in) begin
        mode_out <= M_FAILSAFE;
      end else if (mode_out == M_FAILSAFE) begin
        mode_out  <= M_RESTART;
        rst_count <= RESTART_CYCLES;
      end else if (mode_out == M_SLEEP && (|wake_event_in)) begin
        mode_out  <= M_RESTART;
        rst_count <= RESTART_CYCLES;
      end else if (mode_out == M_RESTART) begin
        // Restart values apply while the dwell counts down.
        watchdog_control_out <= `RST_CFG16;
        high_side_sync_out   <= `RST_HS4;
        if (rst_count <= 32'h00000001) begin
          mode_out <= M_NORMAL;
        end else begin
          rst_count <= rst_count - 32'h00000001;
        end
      end
      interrupt_output_n_out <= ~(stop_int & commit & (count == 6'd32)) & (int_count <= 32'h00000001);
    end
  end

endmodule // spi_slave_command_checker

// file: verilog/spi_checker_consts.vh
// Constants of the serial command checker: frame layout, register addresses,
// field positions, reset values and timing.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SPI_CHECKER_CONSTS_VH
`define SPI_CHECKER_CONSTS_VH

// ====================================================================
// Frame layout.
`define FRAME_BITS        32
`define ADDR_LSB          0
`define ADDR_MSB          6
`define RW_BIT            7
`define DATA_LSB          8
`define DATA_MSB          23

// ====================================================================
// Register addresses (7 bits).
`define ADDR_MODE_CTRL    7'h01
`define ADDR_WATCHDOG_CONTROL_REGISTER      7'h02
`define ADDR_BUS_CTRL     7'h04
`define ADDR_WAKE_CTRL    7'h05
`define ADDR_TIMER_CTRL   7'h07
`define ADDR_HS_CTRL      7'h08
`define ADDR_PIN_CFG      7'h09
`define ADDR_WAKE_STAT    7'h10
`define ADDR_DEV_STAT     7'h11

// ====================================================================
// Field positions and codes.
`define MODE_FLD_LSB      0
`define MODE_FLD_MSB      1
`define MODE_REQ_NORMAL   2'h0
`define MODE_REQ_SLEEP    2'h1
`define MODE_REQ_STOP     2'h2
`define MODE_REQ_RESET    2'h3
`define WAKE_TIMER_BIT    0
`define TIMER_PER_LSB     0
`define TIMER_PER_MSB     7
`define TIMER_ON_LSB      8
`define TIMER_ON_MSB      15
`define PIN_SYNC_BIT      2
`define DEV_SPI_FAIL_BIT  0
`define DEV_CRC_FAIL_BIT  1

// ====================================================================
// Reset values.
`define RST_CFG16         16'h0000
`define RST_HS4           4'h0
`define RST_WSTAT         8'h00

// ====================================================================
// Timing.
`define CLK_PERIOD_NS     10
`define RESTART_TIME_NS   1000
`define INT_LOW_TIME_NS   1000

`endif

// file: verilog/pin_sampler.v
// Two-flip-flop synchroniser with edge detection for a group of pins.
// Assumes pins are asynchronous to clk_in; only the second stage is used.
module pin_sampler #(
  parameter       WIDTH = 3,
  parameter [2:0] IDLE  = 3'h1
) (
  input  wire             clk_in,    // System clock.
  input  wire             rst_in,    // Asynchronous reset, active high.
  input  wire [WIDTH-1:0] pins_in,   // Raw pin levels.
  output wire [WIDTH-1:0] level_out, // Synchronised levels.
  output wire [WIDTH-1:0] rise_out,  // One-cycle pulse on a rising edge.
  output wire [WIDTH-1:0] fall_out   // One-cycle pulse on a falling edge.
);

  reg [WIDTH-1:0] meta;   // First stage, read only by the second stage.
  reg [WIDTH-1:0] stable; // Second stage.
  reg [WIDTH-1:0] prev;   // Previous stable value for edge finding.

  // ====================================================================
  // Synchroniser chain.
  // The chain resets to the idle levels of the pins.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta   <= IDLE[WIDTH-1:0];
      stable <= IDLE[WIDTH-1:0];
      prev   <= IDLE[WIDTH-1:0];
    end else begin
      meta   <= pins_in;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign level_out = stable;
  assign rise_out  = stable & ~prev;
  assign fall_out  = ~stable & prev;

endmodule // pin_sampler

// file: verilog/frame_shifter.v
// Serial shift registers of one frame: input sampled on clock falls,
// output advanced after clock rises, least significant bit first.
// Assumes edge pulses come from synchronised pins on the same clock.
`include "spi_checker_consts.vh"
module frame_shifter #(
  parameter BITS = `FRAME_BITS
) (
  input  wire            clk_in,    // System clock.
  input  wire            rst_in,    // Asynchronous reset, active high.
  input  wire            start_in,  // Frame start pulse.
  input  wire            active_in, // Frame in progress.
  input  wire            rise_in,   // Serial clock rising edge pulse.
  input  wire            fall_in,   // Serial clock falling edge pulse.
  input  wire            sdi_in,    // Synchronised serial input.
  input  wire [BITS-1:0] load_in,   // Word to send in this frame.
  output reg  [BITS-1:0] rx_out,    // Received word.
  output reg  [5:0]      count_out, // Falling edges seen, saturating.
  output wire            sdo_out    // Current output bit.
);

  reg [BITS-1:0] tx; // Output shift register.

  // ====================================================================
  // Shift process.
  // A start reloads the output word and clears the bit count.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_out    <= {BITS{1'b0}};
      tx        <= {BITS{1'b0}};
      count_out <= 6'h00;
    end else if (start_in) begin
      tx        <= load_in;
      count_out <= 6'h00;
    end else if (active_in) begin
      if (fall_in) begin // R4
        rx_out <= {sdi_in, rx_out[BITS-1:1]};
        if (count_out != 6'h3F) begin
          count_out <= count_out + 6'h01;
        end
      end
      if (rise_in) begin // R5
        tx <= {1'b0, tx[BITS-1:1]};
      end
    end
  end

  // Output bits come only from the output register, never from the input.
  assign sdo_out = tx[0]; // R5

endmodule // frame_shifter

// file: tb/spi_checker_sva.sv
// Port checker for the serial command checker.
// Assumes it is bound onto every spi_slave_command_checker instance.
module spi_checker_sva #(
  parameter RESTART_CYCLES = 100,
  parameter INT_CYCLES     = 100
) (
  input wire logic        clk_in,                 // Clock.
  input wire logic        rst_in,                 // Reset, active high.
  input wire logic        csn_in,                 // Chip select pin.
  input wire logic        sdo_oe_out,             // Output enable.
  input wire logic [5:0]  mode_out,               // One-hot mode.
  input wire logic        spi_fail_out,           // Failure flag.
  input wire logic [7:0]  wake_status_out,        // Wake status.
  input wire logic        wd_trigger_out,         // Trigger pulse.
  input wire logic [15:0] pin_cfg_out,            // Pin setup.
  input wire logic        interrupt_output_n_out  // Interrupt, active low.
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==================================================================
  // Port and mode checks.
  oe_release_a: assert property ($rose(csn_in) |-> ##[1:6] !sdo_oe_out) else $error("output kept on");
  port_off_a: assert property ((mode_out[3] || mode_out[4]) |-> !sdo_oe_out) else $error("port live");
  fail_sticky_a: assert property ((spi_fail_out && csn_in) [*8] |=> spi_fail_out) else $error("flag lost");
  stop_late_a: assert property ($rose(mode_out[2]) |-> $past(csn_in, 2)) else $error("early stop");
  stop_sleep_a: assert property ($fell(mode_out[2]) |-> !mode_out[3]) else $error("stop to sleep");
  init_exit_a: assert property ($fell(mode_out[0]) |-> !(mode_out[2] || mode_out[3])) else $error("bad exit");
  stop_flag_a: assert property ($rose(mode_out[2]) |-> $stable(spi_fail_out)) else $error("flag on stop");
  stop_int_a: assert property ($rose(mode_out[2]) && (|wake_status_out) |-> ##[0:2] !interrupt_output_n_out)
    else $error("no interrupt");
  trig_pulse_a: assert property (wd_trigger_out |-> $past(csn_in, 2) ##1 !wd_trigger_out)
    else $error("bad trigger");
  pin_once_a: assert property (!$past(rst_in) && $past(pin_cfg_out) != 16'h0000 |-> $stable(pin_cfg_out))
    else $error("pin rewritten");
endmodule // spi_checker_sva

bind spi_slave_command_checker spi_checker_sva #(.RESTART_CYCLES(RESTART_CYCLES), .INT_CYCLES(INT_CYCLES))
  spi_checker_sva_inst (.clk_in(clk_in), .rst_in(rst_in), .csn_in(csn_in), .sdo_oe_out(sdo_oe_out),
  .mode_out(mode_out), .spi_fail_out(spi_fail_out), .wake_status_out(wake_status_out),
  .wd_trigger_out(wd_trigger_out), .pin_cfg_out(pin_cfg_out), .interrupt_output_n_out(interrupt_output_n_out));

// file: tb/spi_host_model.sv
// Serial master sending frames least significant bit first.
// Assumes the slave samples on clock falls and shifts after rises.
module spi_host_model (
  output logic      csn_out,  // Chip select, active low.
  output logic      sclk_out, // Serial clock, idle low.
  output logic      sdi_out,  // Data to the slave.
  input  wire logic sdo_in    // Data from the slave.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rx; // Word seen from the slave.
  initial begin
    csn_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // Sends n bits; the clock runs only inside the frame.
  task automatic xfer(input logic [31:0] w, input int n);
    csn_out <= 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      #62.5;
      rx[i] = sdo_in;
      sclk_out <= 1'b1;
      sdi_out <= w[i];
      #62.5;
      sclk_out <= 1'b0;
    end
    #60;
    csn_out <= 1'b1;
    sdi_out <= ~sdi_out; // No stale level between frames.
    #200;
  endtask
endmodule // spi_host_model

// file: tb/test_spi_slave_command_checker.sv
// Self-checking bench for the serial command checker.
// Assumes the host model is the only master on the serial pins.
module test_spi_slave_command_checker;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in, rst_in, csn, sclk, sdi, sdo, fail, oe, exp [7]; // Clock, reset, pins, flag.
  logic [7:0]  wake_ev, per;                             // Wake pulses, timer period.
  logic [5:0]  mode;                                     // One-hot mode.
  logic [15:0] wd, tmr, pin, d, t;                       // Register views and data.
  logic [13:0] mcfg;                                     // Other mode bits.
  logic [3:0]  hs;                                       // Sync assignment.
  logic [31:0] cases [7];                                // Words expected to fail or not.
  int          bits [7], miscompares, tests_run, r;
  spi_slave_command_checker #(.RESTART_CYCLES(60), .INT_CYCLES(4)) spi_slave_command_checker_inst (
    .clk_in(clk_in), .rst_in(rst_in), .csn_in(csn), .sclk_in(sclk), .sdi_in(sdi),
    .pwm_or_checksum_select_in(1'b0), .crc_error_in(1'b0), .wake_event_in(wake_ev), .fail_safe_req_in(1'b0),
    .sdo_out(sdo), .sdo_oe_out(oe), .mode_out(mode), .spi_fail_out(fail), .crc_fail_out(),
    .wake_status_out(), .wd_trigger_out(), .watchdog_control_out(wd), .bus_wake_ctrl_out(),
    .wake_source_control_out(), .timer_ctrl_out(tmr), .high_side_sync_out(hs), .pin_cfg_out(pin),
    .mode_cfg_out(mcfg), .interrupt_output_n_out());
  spi_host_model host_inst (.csn_out(csn), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(oe ? sdo : ~sdo));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic close_out();
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, want, seen);
    end
  endtask
  // Builds a write frame.
  function automatic logic [31:0] wr(input logic [6:0] a, input logic [15:0] v);
    return {8'h00, v, 1'b1, a};
  endfunction
  task automatic frame(input logic [31:0] w);
    host_inst.xfer(w, 32);
  endtask
  task automatic clear();
    frame(wr(7'h11, 16'h0001));
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_in) wake_ev <= v;
    @(posedge clk_in) wake_ev <= 8'h00;
  endtask
  // Waits, bounded, for the return to Normal mode.
  task automatic wait_normal();
    int k;
    for (k = 0; k < 300 && mode !== 6'h02; k++) @(posedge clk_in);
    if (k == 300) begin
      miscompares++;
      close_out();
    end
  endtask
  // ==================================================================
  // Main sequence.
  initial begin
    miscompares = 0;
    tests_run = 0;
    r = $urandom(30641);
    rst_in = 1'b1;
    wake_ev = 8'h00;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    frame(wr(7'h01, 16'h0002));
    check("mode", mode, 6'h02);
    check("fail", fail, 1'b1);
    clear();
    check("fail", fail, 1'b0);
    per = 8'($urandom_range(255, 1));
    d = 16'($urandom);
    if (!(^d)) d[0] = ~d[0];
    cases = '{32'hFFFFFFFF, 32'h0, wr(7'h7F, 16'($urandom)), wr(7'h07, {per, per}), wr(7'h08, 16'h0001),
              wr(7'h02, d), 32'hFFFFFFFF};
    bits = '{32, 32, 32, 32, 32, 32, 31};
    exp = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    foreach (cases[i]) begin
      host_inst.xfer(cases[i], bits[i]);
      check("fail", fail, exp[i]);
      clear();
    end
    check("wd", wd, 16'h0000);
    check("timer", tmr, 16'h0000);
    d[0] = ~d[0];
    frame(wr(7'h02, d));
    check("wd", wd, d);
    t = {8'($urandom_range(per - 1, 0)), per};
    frame(wr(7'h07, t));
    repeat (2) frame(32'h00000007);
    check("readback", host_inst.rx[23:8], t);
    check("timer", tmr, t);
    frame(wr(7'h09, 16'h0004));
    frame(wr(7'h09, 16'h0005));
    check("pin", pin, 16'h0004);
    check("fail", fail, 1'b1);
    clear();
    frame(wr(7'h08, 16'h000F));
    check("hs", hs, 4'hF);
    pulse(8'h01);
    frame(wr(7'h01, 16'h0002));
    check("mode", mode, 6'h04);
    check("fail", fail, 1'b0);
    frame(wr(7'h07, 16'h0102));
    check("timer", tmr, t);
    check("fail", fail, 1'b1);
    clear();
    check("fail", fail, 1'b0);
    frame(wr(7'h01, 16'hFFFC));
    check("mode", mode, 6'h02);
    check("cfg", mcfg, 14'h0000);
    frame(wr(7'h01, 16'h0002));
    frame(wr(7'h01, 16'h0001));
    check("mode", mode, 6'h10);
    clear();
    check("fail", fail, 1'b1);
    wait_normal();
    clear();
    frame(wr(7'h01, 16'h0001));
    check("mode", mode, 6'h10);
    check("fail", fail, 1'b1);
    wait_normal();
    clear();
    frame(wr(7'h05, 16'h0002));
    frame(wr(7'h01, 16'h0001));
    check("mode", mode, 6'h08);
    pulse(8'h02);
    wait_normal();
    close_out();
  end
endmodule // test_spi_slave_command_checker
